// ===== rtl/lcd_cfg.svh
// offsets, field positions, reset values and timing counts of the lcd driver
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define LCD_RAM_BASE      16'h53C0
`define LCD_RAM_WINDOW    16'h0040
`define LCD_CLOCKING_CONTROL_REG_ADDR     16'h53A0
`define LCD_DISPLAY_CONTROL_REG_ADDR     16'h53A1
`define RAM_BYTES_LARGE   56
`define RAM_BYTES_SMALL   40
`define SHARED_PINS       4

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CCTL_DUTY_LSB     0
`define CCTL_FRM_LSB      4
`define CCTL_EN_BIT       7
`define DCTL_AREA_BIT     0
`define DCTL_SEG_BIT      1
`define DCTL_COM_BIT      2
`define DCTL_SLOT_LSB     4
`define DUTY_RST          3'h4
`define FRM_RST           2'h1
`define SEG_ORD_RST       1'h1
`define COM_ORD_RST       1'h1

// ----------------------------------------------------------------
// timing: lcd operating clock made from the 25 MHz system clock
// ----------------------------------------------------------------
`define SYS_CLK_HZ        25000000
`define LCD_CLK_HZ        32768
`define LCD_OPERATING_CLOCK_DIV          (`SYS_CLK_HZ / `LCD_CLK_HZ)
`define RATIO_0           256
`define RATIO_1           512
`define RATIO_2           680
`define RATIO_3           1024
`define RATIO3_0          252
`define RATIO3_1          504
`define RATIO3_2          681
`define RATIO3_3          1008

`endif

// ===== rtl/lcd_pkg.sv
// types shared by the lcd driver modules
package lcd_pkg;
    typedef enum logic [2:0] {
        DUTY_STATIC  = 3'h0,
        DUTY_HALF    = 3'h1,
        DUTY_THIRD   = 3'h2,
        DUTY_QUARTER = 3'h3,
        DUTY_EIGHTH  = 3'h4
    } duty_type;
endpackage

// ===== rtl/lcd_frame_divider.sv
// lcd operating clock enable made from the system clock
module lcd_frame_divider #(
    parameter int DIV = 762
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic run,
    output logic      tick
);
    typedef struct packed {
        logic [11:0] cnt;
        logic        tick;
    } state_type;

    state_type s_r;
    state_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (!run) begin
            s_nxt.cnt = 12'h000;
        end else if (s_r.cnt >= 12'(DIV - 1)) begin
            s_nxt.cnt = 12'h000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 12'h001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;
endmodule // lcd_frame_divider

// ===== rtl/lcd_display_ram.sv
// display memory byte array, flattened for the segment mapper
module lcd_display_ram #(
    parameter int BYTES = 56
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               wr_en,
    input  wire logic [5:0]         wr_idx,
    input  wire logic [7:0]         wr_data,
    output logic [BYTES*8-1:0]      mem_bits
);
    typedef struct packed {
        logic [BYTES-1:0][7:0] mem;
    } state_type;

    state_type s_r;
    state_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (wr_en && (int'(wr_idx) < BYTES)) begin
            s_nxt.mem[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mem_bits = s_r.mem;
endmodule // lcd_display_ram

// ===== rtl/lcd_duty_and_display_memory.sv
// lcd duty control, scan timing and display memory mapping
//
// Overview of operation
// R1: three-bit duty code, reset 1/8, 5-7 reserved
// R2: active commons and segments follow the duty
// R3: large part shares four pins as COM/SEG
// R4: small part shares four pins as COM/SEG
// R5: large part has 56 RAM bytes
// R6: small part has 40 RAM bytes
// R7: bit one lights pixel, zero darkens it
// R8: display RAM is fully readable and writable
// R9: unmapped RAM bits are plain storage
// R10: two screen areas outside 1/8 duty
// R11: segment order bit, reset ascending
// R12: common order bit, reset ascending
// R13: 1/8 duty byte and bit mapping
// R14: 1/4 duty byte and area mapping
// R15: frame length from divider select and duty
// R16: registers usable while panel clock stopped
// R17: commons scanned in equal slots
// R18: setting changes apply from next slot (a frame select change here sets the length of the running slot)
`include "lcd_cfg.svh"

module lcd_duty_and_display_memory
    import lcd_pkg::*;
#(
    parameter int RAM_BYTES = `RAM_BYTES_LARGE,
    parameter int LCD_OPERATING_CLOCK_DIV  = `LCD_OPERATING_CLOCK_DIV
) (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic [15:0]          addr,
    input  wire logic [7:0]           wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic [7:0]                rdata,
    output logic [3:0]                com_pin,
    output logic [`SHARED_PINS-1:0]   shared_pin,
    output logic [RAM_BYTES-5:0]      seg_pin
);
    localparam int SEG_DED = RAM_BYTES - `SHARED_PINS;

    typedef struct packed {
        logic [2:0]           duty;
        logic [1:0]           frm_sel;
        logic                 lcd_en;
        logic                 area;
        logic                 seg_ord;
        logic                 com_ord;
        logic [2:0]           scan_duty;
        logic                 scan_area;
        logic                 scan_seg_ord;
        logic                 scan_com_ord;
        logic [10:0]          slot_cnt;
        logic [2:0]           slot;
        logic [7:0]           rdata;
        logic [3:0]           com_pin;
        logic [3:0]           shared_pin;
        logic [SEG_DED-1:0]   seg_pin;
    } state_type;

    state_type                s_r;
    state_type                s_nxt;
    logic                     lcd_tick;
    logic [RAM_BYTES*8-1:0]   mem;
    logic [15:0]              ram_off;
    logic                     ram_hit;
    logic [7:0]               ram_byte;
    logic [3:0]               ncom;
    logic [6:0]               nseg;
    logic [2:0]               bit_sel;
    logic [10:0]              slot_len;
    logic                     slot_end;
    logic [7:0]               com_line;
    logic [RAM_BYTES-1:0]     pix;

    // ----------------------------------------------------------------
    // duty derived line counts and slot length
    // ----------------------------------------------------------------
    function automatic logic [3:0] com_count(input logic [2:0] d);
        case (d)
            DUTY_EIGHTH:  com_count = 4'h8;
            DUTY_QUARTER: com_count = 4'h4;
            DUTY_THIRD:   com_count = 4'h3;
            DUTY_HALF:    com_count = 4'h2;
            DUTY_STATIC:  com_count = 4'h1;
            default:      com_count = 4'h0;
        endcase
    endfunction

    // one frame split evenly over the scanned commons
    function automatic logic [10:0] slot_length(input logic [2:0] d, input logic [1:0] f);
        logic [10:0] r;
        r = 11'h000;
        case (f)
            2'h0:    r = (d == DUTY_THIRD) ? 11'(`RATIO3_0 / 3) : 11'(`RATIO_0);
            2'h1:    r = (d == DUTY_THIRD) ? 11'(`RATIO3_1 / 3) : 11'(`RATIO_1);
            2'h2:    r = (d == DUTY_THIRD) ? 11'(`RATIO3_2 / 3) : 11'(`RATIO_2);
            default: r = (d == DUTY_THIRD) ? 11'(`RATIO3_3 / 3) : 11'(`RATIO_3);
        endcase
        case (d)
            DUTY_EIGHTH:  slot_length = r >> 3;
            DUTY_QUARTER: slot_length = r >> 2;
            DUTY_HALF:    slot_length = r >> 1;
            default:      slot_length = r;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // sub blocks
    // ----------------------------------------------------------------
    // the panel clock only gates scanning; the bus side never waits on it
    lcd_frame_divider #(
        .DIV (LCD_OPERATING_CLOCK_DIV)
    ) u_div (
        .clk  (clk),
        .nrst (nrst),
        .run  (s_r.lcd_en),
        .tick (lcd_tick)
    ); // [R16]

    lcd_display_ram #(
        .BYTES (RAM_BYTES)
    ) u_ram (
        .clk      (clk),
        .nrst     (nrst),
        .wr_en    (wr && ram_hit),
        .wr_idx   (ram_off[5:0]),
        .wr_data  (wdata),
        .mem_bits (mem)
    ); // [R5] [R6] [R8] [R9]

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign ram_off  = addr - `LCD_RAM_BASE;
    assign ram_hit  = (addr >= `LCD_RAM_BASE) && (ram_off < 16'(RAM_BYTES)); // [R5] [R6] [R13]
    assign ram_byte = ram_hit ? mem[ram_off[5:0]*8 +: 8] : 8'h00;

    // ----------------------------------------------------------------
    // memory to panel mapping
    // ----------------------------------------------------------------
    assign ncom     = com_count(s_r.scan_duty); // [R2]
    assign nseg     = (s_r.scan_duty == DUTY_EIGHTH) ? 7'(SEG_DED) : 7'(RAM_BYTES); // [R2]
    assign slot_len = slot_length(s_r.scan_duty, s_r.frm_sel); // [R15]
    assign slot_end = lcd_tick && (s_r.slot_cnt >= slot_len - 11'h001);

    // area bit only acts below 1/8 duty, where a byte holds two screens
    always_comb begin
        bit_sel = s_r.scan_com_ord ? s_r.slot : 3'(ncom - 4'h1 - 4'(s_r.slot)); // [R12]
        if ((s_r.scan_duty != DUTY_EIGHTH) && s_r.scan_area) begin
            bit_sel = bit_sel + 3'h4; // [R10] [R14]
        end
    end

    for (genvar g = 0; g < RAM_BYTES; g++) begin : g_seg
        logic [5:0] byte_sel;
        always_comb begin
            byte_sel = s_r.scan_seg_ord ? 6'(g) : 6'(nseg - 7'h01 - 7'(g)); // [R11]
            pix[g] = 1'b0;
            if (7'(g) < nseg) begin
                pix[g] = mem[{byte_sel, bit_sel}]; // [R7] [R13] [R14]
            end
        end
    end

    for (genvar c = 0; c < 8; c++) begin : g_com
        assign com_line[c] = s_r.lcd_en && (s_r.slot == 3'(c)) && (4'(c) < ncom); // [R17]
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;

        if (wr && (addr == `LCD_CLOCKING_CONTROL_REG_ADDR)) begin
            s_nxt.duty    = wdata[`CCTL_DUTY_LSB +: 3]; // [R1]
            s_nxt.frm_sel = wdata[`CCTL_FRM_LSB +: 2]; // [R15]
            s_nxt.lcd_en  = wdata[`CCTL_EN_BIT];
        end
        if (wr && (addr == `LCD_DISPLAY_CONTROL_REG_ADDR)) begin
            s_nxt.area    = wdata[`DCTL_AREA_BIT]; // [R10]
            s_nxt.seg_ord = wdata[`DCTL_SEG_BIT]; // [R11]
            s_nxt.com_ord = wdata[`DCTL_COM_BIT]; // [R12]
        end

        if (rd) begin
            if (ram_hit) begin
                s_nxt.rdata = ram_byte; // [R8]
            end else if (addr == `LCD_CLOCKING_CONTROL_REG_ADDR) begin
                s_nxt.rdata = {s_r.lcd_en, 1'b0, s_r.frm_sel, 1'b0, s_r.duty};
            end else if (addr == `LCD_DISPLAY_CONTROL_REG_ADDR) begin
                s_nxt.rdata = {1'b0, s_r.slot, 1'b0, s_r.com_ord, s_r.seg_ord, s_r.area};
            end
        end

        // scan: duty, area and order settings are sampled at a slot edge, and every cycle while lcd_en is low
        if (!s_r.lcd_en) begin
            s_nxt.slot_cnt     = 11'h000;
            s_nxt.slot         = 3'h0;
            s_nxt.scan_duty    = s_r.duty;
            s_nxt.scan_area    = s_r.area;
            s_nxt.scan_seg_ord = s_r.seg_ord;
            s_nxt.scan_com_ord = s_r.com_ord;
        end else if (slot_end) begin
            s_nxt.slot_cnt     = 11'h000;
            s_nxt.scan_duty    = s_r.duty; // [R18]
            s_nxt.scan_area    = s_r.area; // [R18]
            s_nxt.scan_seg_ord = s_r.seg_ord; // [R18]
            s_nxt.scan_com_ord = s_r.com_ord; // [R18]
            if (4'(s_r.slot) + 4'h1 >= com_count(s_r.duty)) begin
                s_nxt.slot = 3'h0; // [R17]
            end else begin
                s_nxt.slot = s_r.slot + 3'h1; // [R17]
            end
        end else if (lcd_tick) begin
            s_nxt.slot_cnt = s_r.slot_cnt + 11'h001; // [R17]
        end

        // panel pins, dark while the panel clock is stopped
        s_nxt.com_pin = com_line[3:0];
        // a reserved duty scans no common, so its segments stay dark too
        s_nxt.seg_pin = (s_r.lcd_en && (ncom != 4'h0)) ? pix[SEG_DED-1:0] : '0; // [R16] [R1]
        for (int i = 0; i < `SHARED_PINS; i++) begin
            if (s_r.scan_duty == DUTY_EIGHTH) begin
                s_nxt.shared_pin[i] = com_line[4+i]; // [R3] [R4]
            end else begin
                s_nxt.shared_pin[i] = s_r.lcd_en && (ncom != 4'h0) && pix[RAM_BYTES-1-i]; // [R3] [R4]
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r              <= '0;
            s_r.duty         <= `DUTY_RST; // [R1]
            s_r.frm_sel      <= `FRM_RST;
            s_r.seg_ord      <= `SEG_ORD_RST; // [R11]
            s_r.com_ord      <= `COM_ORD_RST; // [R12]
            s_r.scan_duty    <= `DUTY_RST;
            s_r.scan_seg_ord <= `SEG_ORD_RST;
            s_r.scan_com_ord <= `COM_ORD_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata      = s_r.rdata;
    assign com_pin    = s_r.com_pin;
    assign shared_pin = s_r.shared_pin;
    assign seg_pin    = s_r.seg_pin;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence ram_write_s;
        wr && ram_hit && !rd;
    endsequence

    sequence same_addr_read_s;
        rd && !wr && ($stable(addr));
    endsequence

    sequence slot_edge_s;
        s_r.lcd_en && slot_end;
    endsequence

    ram_read_a: assert property (rd && ram_hit && !wr |=> rdata == $past(ram_byte)) // [R8]
        else $error("ram read data wrong");

    write_back_a: assert property (ram_write_s ##1 same_addr_read_s |=> rdata == $past(wdata, 2)) // [R8]
        else $error("ram byte not kept");

    spare_read_a: assert property (rd && !ram_hit && (addr >= `LCD_RAM_BASE)
                                   && (addr < `LCD_RAM_BASE + `LCD_RAM_WINDOW) |=> rdata == 8'h00) // [R13]
        else $error("unavailable byte reads nonzero");

    duty_write_a: assert property (wr && addr == `LCD_CLOCKING_CONTROL_REG_ADDR |=> s_r.duty == $past(wdata[2:0])) // [R1]
        else $error("duty field not stored");

    slot_range_a: assert property (s_r.lcd_en && ncom != 4'h0 |-> 4'(s_r.slot) < ncom) // [R2]
        else $error("scan slot beyond active commons");

    shared_com_a: assert property (s_r.scan_duty == DUTY_EIGHTH |=> shared_pin == $past(com_line[7:4])) // [R3]
        else $error("shared pins not commons at 1/8");

    slot_restart_a: assert property (slot_edge_s |=> s_r.slot_cnt == 11'h000) // [R17]
        else $error("slot counter not restarted");

    cfg_hold_a: assert property (s_r.lcd_en && !slot_end |=> $stable(s_r.scan_duty)
                                 && $stable(s_r.scan_area)) // [R18]
        else $error("scan settings changed mid slot");

    stopped_dark_a: assert property (!s_r.lcd_en ##1 !s_r.lcd_en |-> com_pin == 4'h0
                                     && shared_pin == 4'h0 && seg_pin == '0) // [R16]
        else $error("panel driven with clock stopped");

    seg_order_a: assert property (s_r.scan_seg_ord |-> pix[0] == mem[bit_sel]) // [R11]
        else $error("first segment not from first byte");

    reserved_blank_a: assert property (ncom == 4'h0 |=> seg_pin == '0 && com_pin == 4'h0) // [R1]
        else $error("reserved duty drives the panel");
endmodule // lcd_duty_and_display_memory

// ===== testbench/lcd_panel_model.sv
// passive dot-matrix panel: decodes which common line is being scanned
module lcd_panel_model
    import lcd_pkg::*;
(
    input  wire logic       eighth,
    input  wire logic [3:0] com_lo,
    input  wire logic [3:0] com_hi,
    output logic [3:0]      com_idx,
    output logic            multi
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // common decode
    // ----------------------------------------------------------------
    // upper four commons only wired when the panel is an eight-common one
    logic [7:0] lines;

    always_comb begin
        lines   = eighth ? {com_hi, com_lo} : {4'h0, com_lo};
        com_idx = 4'hF;
        multi   = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (lines[i]) begin
                multi   = multi | (com_idx != 4'hF);
                com_idx = 4'(i);
            end
        end
    end
endmodule // lcd_panel_model

// ===== testbench/lcd_duty_and_display_memory_tb_top.sv
// self-checking bench for the lcd duty control and display memory block
`include "lcd_cfg.svh"

module lcd_duty_and_display_memory_tb_top
    import lcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] el; logic [7:0] es;} row_type;
    typedef struct packed {logic [7:0] c; logic [15:0] len;} frm_type;
    typedef struct packed {logic [7:0] dctl; logic [3:0] slot; logic [3:0] exp;} scan_type;

    logic        clk, nrst, wr, rd, eighth, multi;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, rdata_s, d, ds;
    logic [3:0]  com_pin, shared_pin, com_s, shared_s, com_idx;
    logic [51:0] seg_pin;
    logic [35:0] seg_s;
    int          mismatches, n_compared;

    // bus tables: large and small part see the same traffic
    row_type rows [10] = '{'{16'h53C0, 8'h21, 8'h21, 8'h21}, '{16'h53E7, 8'h22, 8'h22, 8'h22},
                           '{16'h53E8, 8'h5A, 8'h5A, 8'h00}, '{16'h53F4, 8'hA5, 8'hA5, 8'h00},
                           '{16'h53F7, 8'h12, 8'h12, 8'h00}, '{16'h53F8, 8'hFF, 8'h00, 8'h00},
                           '{16'h5000, 8'hFF, 8'h00, 8'h00}, '{16'h53FF, 8'h3C, 8'h00, 8'h00},
                           '{16'h53A1, 8'hFF, 8'h07, 8'h07}, '{16'h53A0, 8'h4B, 8'h03, 8'h03}};
    // slot length in clocks = LCD_OPERATING_CLOCK_DIV * ratio / commons, LCD_OPERATING_CLOCK_DIV = 2
    frm_type frms [7] = '{'{8'h81, 16'd256}, '{8'h82, 16'd168}, '{8'h83, 16'd128}, '{8'hA3, 16'd340},
                          '{8'hA2, 16'd454}, '{8'h84, 16'd64}, '{8'hB4, 16'd256}};
    // exp = {seg0 large, seg55 large, seg39 small, two commons at once}
    scan_type scans [6] = '{'{8'h06, 4'h0, 4'b1000}, '{8'h06, 4'h1, 4'b0110}, '{8'h07, 4'h0, 4'b0100},
                            '{8'h07, 4'h1, 4'b1010}, '{8'h05, 4'h0, 4'b1000}, '{8'h03, 4'h2, 4'b1010}};

    lcd_duty_and_display_memory #(.RAM_BYTES(56), .LCD_OPERATING_CLOCK_DIV(2)) DUT (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .com_pin(com_pin), .shared_pin(shared_pin), .seg_pin(seg_pin));
    lcd_duty_and_display_memory #(.RAM_BYTES(40), .LCD_OPERATING_CLOCK_DIV(2)) DUT_S (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_s),
        .com_pin(com_s), .shared_pin(shared_s), .seg_pin(seg_s));
    lcd_panel_model PANEL (.eighth(eighth), .com_lo(com_pin), .com_hi(shared_pin),
        .com_idx(com_idx), .multi(multi));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d  = rdata;
        ds = rdata_s;
    endtask

    // leave slot k, then come back to it: at least one slot boundary passes
    task automatic wait_idx(input logic [3:0] k);
        int n;
        n = 0;
        while (com_idx === k && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        while (com_idx !== k && n < 10000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 10000) begin
            mismatches++;
            $display("BAD t=%0t wait com=%h n=%h", $time, k, n);
        end
    endtask

    task automatic measure(input logic [3:0] k, input logic [15:0] len);
        int n;
        wait_idx(k);
        n = 0;
        while (com_idx === k && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, len);
    endtask

    task automatic give_verdict();
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // whole run is at most about 9k clocks; allow about nine times that before giving up
    initial begin
        repeat (80000) @(posedge clk);
        mismatches++;
        $display("BAD t=%0t watchdog %h %h", $time, n_compared, mismatches);
        give_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = 16'h0000; wdata = 8'h00; eighth = 1'b1;
        mismatches = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        bus_rd(`LCD_CLOCKING_CONTROL_REG_ADDR);
        chk({d, ds}, 16'h1414);
        @(posedge clk);
        #1;
        chk(rdata, 8'h00);
        bus_rd(`LCD_DISPLAY_CONTROL_REG_ADDR);
        chk({d, ds}, 16'h0606);
        chk({com_pin, shared_pin, seg_pin}, 60'h0);
        $display("test reset done");
        // panel clock still off here: all access works without it
        foreach (rows[i]) begin
            bus_wr(rows[i].a, rows[i].d);
            bus_rd(rows[i].a);
            chk({d, ds}, {rows[i].el, rows[i].es});
        end
        $display("test memory map done");
        bus_wr(`LCD_CLOCKING_CONTROL_REG_ADDR, 8'h80);
        eighth = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        chk({com_pin, com_s}, 8'h11);
        foreach (frms[i]) begin
            bus_wr(`LCD_CLOCKING_CONTROL_REG_ADDR, frms[i].c);
            eighth = (frms[i].c[2:0] == 3'h4);
            measure(4'h1, frms[i].len);
        end
        $display("test slot length done");
        bus_wr(`LCD_CLOCKING_CONTROL_REG_ADDR, 8'h83);
        eighth = 1'b0;
        foreach (scans[i]) begin
            bus_wr(`LCD_DISPLAY_CONTROL_REG_ADDR, scans[i].dctl);
            wait_idx(scans[i].slot);
            chk({seg_pin[0], shared_pin[0], shared_s[0], multi}, scans[i].exp);
        end
        $display("test pixel mapping done");
        bus_wr(`LCD_DISPLAY_CONTROL_REG_ADDR, 8'h06);
        bus_wr(`LCD_CLOCKING_CONTROL_REG_ADDR, 8'h84);
        eighth = 1'b1;
        wait_idx(4'h5);
        chk({com_pin, shared_pin, shared_s, seg_pin[0]}, {4'h0, 4'h2, 4'h2, 1'b1});
        $display("test eighth duty done");
        // reserved code must blank the panel rather than guess a duty
        bus_wr(`LCD_CLOCKING_CONTROL_REG_ADDR, 8'h85);
        repeat (200) @(posedge clk);
        #1;
        chk({com_pin, shared_pin, seg_pin}, 60'h0);
        bus_wr(`LCD_CLOCKING_CONTROL_REG_ADDR, 8'h04);
        repeat (5) @(posedge clk);
        #1;
        chk({com_pin, shared_pin, seg_pin}, 60'h0);
        bus_rd(16'h53F4);
        chk({d, ds}, 16'hA500);
        $display("test reserved and stop done");
        give_verdict();
    end
endmodule // lcd_duty_and_display_memory_tb_top
